// ---- bench/ata_drive_model.sv ----
`timescale 1ns/1ps
module ata_drive_model (
    input wire logic mclk,
    input wire logic [2:0] addr,
    input wire logic selN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic [15:0] busIn,
    input wire logic wide,
    input wire logic [3:0] stall,
    output logic readyLow,
    output logic wideN,
    output logic dataOe,
    output logic [15:0] dataOut,
    output logic [15:0] lastWr
);
    logic [3:0] cnt;
    // drives both levels; the bench inverts it onto driveChannelReady
    assign readyLow = !(rdN && wrN) && cnt < stall;
    assign wideN = !(wide && !selN);
    assign dataOe = !selN && !rdN;
    assign dataOut = 16'h5a30 | 16'(addr);
    always_ff @(posedge mclk)
    begin
        if (rdN && wrN)
            cnt <= 4'h0;
        else if (cnt != 4'hf)
            cnt <= cnt + 4'h1;
    end
    always @(posedge wrN)
        if (!selN)
            lastWr <= busIn;
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
    import ide_strap_pkg::*;
    localparam int CLKS [4] = '{CYCLE_MODE0_CLKS, CYCLE_MODE1_CLKS, CYCLE_MODE2_CLKS,
        CYCLE_MODE3_CLKS};
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    ide_req_s req = '0;
    logic reqReady, rspValid, rspWide, regWr = 1'b0, regRd = 1'b0;
    logic [15:0] rspData, dbOut, dbOe, dbIn, pData, lastWr;
    logic [3:0] regAddr = 4'h0;
    logic [3:0] stall = 4'h0;
    logic [7:0] regWrData = 8'h0;
    logic [7:0] regRdData;
    logic [1:0] aLowOut, aLowOe, aLow, sLow;
    logic aMsbOut, aMsbOe, aMsb, sMsb, cmdOut, cmdOe, cmdN, sCmd, ctlOut, ctlOe, ctlN, sCtl;
    logic rdN, rdOe, wrN, wrOe, testN, nandOut, nandOe, pref, spd, flop, readyLow, wideN;
    logic pOe, wide = 1'b1;
    int n_mismatch = 0;
    int n_tests = 0;

    always #5 mclk = ~mclk;
    // released pins fall back to the strap resistors, the data bus to its pull-ups
    assign aLow = (aLowOe & aLowOut) | (~aLowOe & sLow);
    assign aMsb = aMsbOe ? aMsbOut : sMsb;
    assign cmdN = cmdOe ? cmdOut : sCmd;
    assign ctlN = ctlOe ? ctlOut : sCtl;
    assign dbIn = (dbOe & dbOut) | (~dbOe & (pOe ? pData : 16'hffff));

    ide_strap_and_drive_select i_dut (.mclk(mclk), .resetn(resetn), .req(req),
        .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspWide(rspWide),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .driveAddrLowIn(aLow), .driveAddrLowOut(aLowOut),
        .driveAddrLowOe(aLowOe), .driveAddrMsbIn(aMsb), .driveAddrMsbOut(aMsbOut),
        .driveAddrMsbOe(aMsbOe), .primaryCommandSelectNIn(cmdN),
        .primaryCommandSelectNOut(cmdOut), .primaryCommandSelectNOe(cmdOe),
        .primaryControlSelectNIn(ctlN), .primaryControlSelectNOut(ctlOut),
        .primaryControlSelectNOe(ctlOe), .driveReadStrobeN(rdN), .driveReadStrobeOe(rdOe),
        .driveWriteStrobeN(wrN), .driveWriteStrobeOe(wrOe), .driveChannelReady(!readyLow),
        .driveWideTransferN(wideN), .testModeStrapN(testN), .diskDataBusIn(dbIn),
        .diskDataBusOut(dbOut), .diskDataBusOe(dbOe), .nandChainOut(nandOut),
        .nandChainOe(nandOe), .prefetchEnable(pref), .busSpeed25(spd),
        .floppyPortIgnore(flop));

    ata_drive_model i_drive (.mclk(mclk), .addr({aMsb, aLow}), .selN(cmdN & ctlN),
        .rdN(rdOe ? rdN : 1'b1), .wrN(wrOe ? wrN : 1'b1), .busIn(dbIn), .wide(wide),
        .stall(stall), .readyLow(readyLow), .wideN(wideN), .dataOe(pOe), .dataOut(pData),
        .lastWr(lastWr));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic rst(input logic [1:0] m, input logic s, input logic t);
        testN <= t;
        sLow <= m;
        sMsb <= s;
        sCmd <= m[1];
        sCtl <= ~s;
        resetn <= 1'b0;
        repeat (12) @(posedge mclk);
        chk(16'({aLowOe, aMsbOe, cmdOe, ctlOe, rdOe, wrOe, |dbOe}), 16'h0);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    task automatic rreg(input logic [3:0] a, input logic [7:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 chk(16'(regRdData), 16'(e));
    endtask

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        #1;
    endtask

    // drive transfer; lat counts edges from take to response, low counts strobe cycles
    task automatic xfer(input logic w, input logic c, input logic [2:0] a,
        input logic [15:0] d, output int lat, output int low);
        int k = 0;
        req <= '{1'b1, w, c, a, d};
        do @(posedge mclk); while (!reqReady && ++k < 300);
        req.valid <= 1'b0;
        lat = 0;
        low = 0;
        // the previous answer still stands at the take edge, so look only after it
        do
        begin
            @(posedge mclk);
            #1 lat++;
            if (!(w ? wrN : rdN))
            begin
                low++;
                chk(16'({aMsb, aLow}), 16'(a));
                chk(16'({cmdN, ctlN}), c ? 16'h2 : 16'h1);
            end
        end
        while (!rspValid && lat < 300);
        if (lat >= 300 || k >= 300)
        begin
            n_mismatch++;
            end_sim();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int lat;
        int low;
        logic [6:0] v;
        for (int m = 0; m < 4; m++)
        begin
            rst(2'(m), m[0], 1'b1);
            rreg(REG_STRAP, {~m[0], m[0], 2'h0, 1'b1, 2'(m), m[1]});
            rreg(REG_MISC, {1'b0, m[0], 6'h0});
            chk(16'({pref, spd, flop}), 16'({m[0], m[1], ~m[0]}));
            wide <= 1'b1;
            xfer(1'b0, 1'b0, 3'h0, 16'h0, lat, low);
            chk(rspData, 16'h5a30);
            chk(16'(rspWide), 16'h1);
            chk(16'(lat >= CLKS[m]), 16'h1);
            wide <= 1'b0;
            stall <= 4'hc;
            xfer(1'b0, 1'b1, 3'h5, 16'h0, lat, low);
            chk(rspData, 16'h0035);
            chk(16'(low >= 12), 16'h1);
            stall <= 4'h0;
            xfer(1'b1, 1'b1, 3'h6, 16'hc3e1, lat, low);
            chk(lastWr, 16'hc3e1);
            chk(16'(lat >= CLKS[m]), 16'h1);
            $display("strap mode %0d done", m);
        end
        wreg(REG_MISC, 8'h00);
        rreg(REG_MISC, 8'h00);
        chk(16'(pref), 16'h0);
        wreg(REG_STRAP, 8'h00);
        rreg(REG_STRAP, 8'h4f);
        rreg(4'hf, 8'h00);
        $display("registers done");
        for (int t = 0; t < 4; t++)
        begin
            rst(2'(t), 1'b0, 1'b0);
            repeat (3) @(posedge mclk);
            #1 chk(16'(reqReady), 16'h0);
            v = {wrN, rdN, ctlOut, cmdOut, aMsbOut, aLowOut};
            if (t == 0)
                chk(16'({aLowOe, aMsbOe, cmdOe, ctlOe, rdOe, wrOe, nandOe, |dbOe}), 16'h0);
            // the test strap sits last in the chain and is low here, so the chain ends high
            if (t == 1)
                chk(16'({nandOut, nandOe, |dbOe}), 16'h6);
            for (int i = 0; i < 7 && t > 1; i++)
                chk(16'(v[i]), 16'((PIN_NUMBER[i] % 2 == 1) ^ (t == 2)));
            $display("test mode %0d done", t);
        end
        end_sim();
    end
endmodule

// ---- rtl/ide_strap_and_drive_select.sv ----
`timescale 1ns/1ps
module ide_strap_and_drive_select (
    input wire logic mclk,
    input wire logic resetn,
    input wire ide_strap_pkg::ide_req_s req,
    output logic reqReady,
    output logic rspValid,
    output logic [15:0] rspData,
    output logic rspWide,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic [1:0] driveAddrLowIn,
    output logic [1:0] driveAddrLowOut,
    output logic [1:0] driveAddrLowOe,
    input wire logic driveAddrMsbIn,
    output logic driveAddrMsbOut,
    output logic driveAddrMsbOe,
    input wire logic primaryCommandSelectNIn,
    output logic primaryCommandSelectNOut,
    output logic primaryCommandSelectNOe,
    input wire logic primaryControlSelectNIn,
    output logic primaryControlSelectNOut,
    output logic primaryControlSelectNOe,
    output logic driveReadStrobeN,
    output logic driveReadStrobeOe,
    output logic driveWriteStrobeN,
    output logic driveWriteStrobeOe,
    input wire logic driveChannelReady,
    input wire logic driveWideTransferN,
    input wire logic testModeStrapN,
    input wire logic [15:0] diskDataBusIn,
    output logic [15:0] diskDataBusOut,
    output logic [15:0] diskDataBusOe,
    output logic nandChainOut,
    output logic nandChainOe,
    output logic prefetchEnable,
    output logic busSpeed25,
    output logic floppyPortIgnore
);
    import ide_strap_pkg::*;

    typedef struct packed {
        phase_e phase;
        logic [6:0] cnt;
        logic [6:0] cycleLen;
        logic [6:0] activeLen;
        ide_req_s cur;
        logic [PIN_COUNT-1:0] pinOut;
        logic [PIN_COUNT-1:0] pinOe;
        logic [15:0] rdData;
        logic rdWide;
        logic rspValid;
        logic reqReady;
        logic prefetch;
        logic [7:0] regRdData;
    } state_s;

    state_s q;
    state_s d;
    strap_s strap;
    logic [PIN_COUNT-1:0] testOut;
    logic [PIN_COUNT-1:0] testOe;
    logic [CHAIN_WIDTH-1:0] chainIn;
    logic [7:0] readMux;
    logic [15:0] wideData;

    ////////////////////////////////////////////////////////////////////////////////
    strap_capture u_strap (
        .mclk(mclk),
        .resetn(resetn),
        .capture(q.phase == ST_INIT),
        .modePins(driveAddrLowIn),
        .prefetchPin(driveAddrMsbIn),
        .testPinN(testModeStrapN),
        .speedPin(primaryCommandSelectNIn),
        .floppyPin(primaryControlSelectNIn),
        .strap(strap)
    );

    assign chainIn = {testModeStrapN, driveWideTransferN, driveChannelReady, diskDataBusIn,
                      primaryControlSelectNIn, primaryCommandSelectNIn, driveAddrMsbIn,
                      driveAddrLowIn};

    test_pattern u_pattern (
        .mode(strap.mode),
        .chainIn(chainIn),
        .pinOut(testOut),
        .pinOe(testOe)
    );

    // an eight-bit drive leaves the upper lines to the pull-ups
    assign wideData = driveWideTransferN ? {8'h00, diskDataBusIn[7:0]} : diskDataBusIn;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        readMux = 8'h00;
        case (regAddr)
            REG_STRAP:
            begin
                readMux[STRAP_SPEED_BIT] = strap.speed25;
                readMux[STRAP_MODE_LSB +: 2] = strap.mode;
                readMux[STRAP_TEST_BIT] = strap.testModeN;
                readMux[STRAP_PREF_BIT] = strap.prefetch;
                readMux[STRAP_FLOPPY_BIT] = strap.floppyIgnore;
            end
            REG_MISC:
                readMux[MISC_PREFETCH_BIT] = q.prefetch;
            REG_STATUS:
            begin
                readMux[STAT_BUSY_BIT] = (q.phase != ST_IDLE);
                readMux[STAT_TEST_BIT] = (q.phase == ST_TEST);
                readMux[STAT_WIDE_BIT] = q.rdWide;
            end
            default:
                readMux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        d = q;
        d.rspValid = 1'b0;
        case (q.phase)
            ST_INIT:
            begin
                // pins still float, so the inputs show the straps
                d.prefetch = driveAddrMsbIn;
                d.phase = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (!strap.testModeN && q.reqReady)
                    d.phase = ST_TEST;
                else if (q.reqReady)
                begin
                    d.pinOe = NORMAL_OE;
                    if (req.valid)
                    begin
                        d.cur = req;
                        d.cnt = 7'h00;
                        d.cycleLen = cyclesFor(strap.mode);
                        d.activeLen = cyclesFor(strap.mode) >> 1;
                        d.pinOut[IDX_ADDR_HI:IDX_ADDR_LO] = req.addr;
                        d.pinOut[IDX_CS_CMD] = req.ctrlBlock;
                        d.pinOut[IDX_CS_CTL] = ~req.ctrlBlock;
                        d.pinOut[IDX_NAND-1:IDX_DATA_LO] = req.data;
                        d.pinOe = req.write ? (NORMAL_OE | DATA_OE) : NORMAL_OE;
                        d.phase = ST_SETUP;
                    end
                end
            end
            ST_SETUP:
            begin
                d.cnt = q.cnt + 7'h01;
                if (q.cur.write)
                    d.pinOut[IDX_WR] = 1'b0;
                else
                    d.pinOut[IDX_RD] = 1'b0;
                d.phase = ST_STROBE;
            end
            ST_STROBE:
            begin
                // saturate so a long stretch cannot wrap the count
                if (q.cnt != 7'h7f)
                    d.cnt = q.cnt + 7'h01;
                if (q.cnt >= q.activeLen && driveChannelReady)
                begin
                    d.pinOut[IDX_RD] = 1'b1;
                    d.pinOut[IDX_WR] = 1'b1;
                    d.rdData = q.cur.write ? 16'h0000 : wideData;
                    d.rdWide = ~driveWideTransferN;
                    d.phase = ST_RECOVER;
                end
            end
            ST_RECOVER:
            begin
                if (q.cnt != 7'h7f)
                    d.cnt = q.cnt + 7'h01;
                // data stays driven past the strobe rise for hold
                if (q.cnt >= q.cycleLen - 7'h01)
                begin
                    d.pinOut[IDX_CS_CMD] = 1'b1;
                    d.pinOut[IDX_CS_CTL] = 1'b1;
                    d.pinOe = NORMAL_OE;
                    d.rspValid = 1'b1;
                    d.phase = ST_IDLE;
                end
            end
            ST_TEST:
            begin
                // only a reset leaves test operation
                d.pinOut = testOut;
                d.pinOe = testOe;
            end
            default:
                d.phase = ST_INIT;
        endcase
        if (regWr && regAddr == REG_MISC)
            d.prefetch = regWrData[MISC_PREFETCH_BIT];
        d.regRdData = regRd ? readMux : 8'h00;
        d.reqReady = (d.phase == ST_IDLE) && (q.phase != ST_INIT);
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            q <= '0;
            q.phase <= ST_INIT;
            q.pinOut <= PIN_OUT_RESET;
            q.pinOe <= '0;
            q.prefetch <= MISC_PREFETCH_RESET;
        end
        else
            q <= d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign reqReady = q.reqReady;
    assign rspValid = q.rspValid;
    assign rspData = q.rdData;
    assign rspWide = q.rdWide;
    assign regRdData = q.regRdData;
    assign driveAddrLowOut = q.pinOut[IDX_ADDR_LO +: 2];
    assign driveAddrLowOe = q.pinOe[IDX_ADDR_LO +: 2];
    assign driveAddrMsbOut = q.pinOut[IDX_ADDR_HI];
    assign driveAddrMsbOe = q.pinOe[IDX_ADDR_HI];
    assign primaryCommandSelectNOut = q.pinOut[IDX_CS_CMD];
    assign primaryCommandSelectNOe = q.pinOe[IDX_CS_CMD];
    assign primaryControlSelectNOut = q.pinOut[IDX_CS_CTL];
    assign primaryControlSelectNOe = q.pinOe[IDX_CS_CTL];
    assign driveReadStrobeN = q.pinOut[IDX_RD];
    assign driveReadStrobeOe = q.pinOe[IDX_RD];
    assign driveWriteStrobeN = q.pinOut[IDX_WR];
    assign driveWriteStrobeOe = q.pinOe[IDX_WR];
    assign diskDataBusOut = q.pinOut[IDX_NAND-1:IDX_DATA_LO];
    assign diskDataBusOe = q.pinOe[IDX_NAND-1:IDX_DATA_LO];
    assign nandChainOut = q.pinOut[IDX_NAND];
    assign nandChainOe = q.pinOe[IDX_NAND];
    assign prefetchEnable = q.prefetch;
    assign busSpeed25 = strap.speed25;
    assign floppyPortIgnore = strap.floppyIgnore;

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] sinceStart;
    logic inCycle;

    assign inCycle = (q.phase == ST_SETUP) || (q.phase == ST_STROBE) || (q.phase == ST_RECOVER);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            sinceStart <= 8'h00;
        else if (!inCycle)
            sinceStart <= 8'h00;
        else if (sinceStart != 8'hff)
            sinceStart <= sinceStart + 8'h01;
    end

    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence stretchS;
        q.phase == ST_STROBE && !driveChannelReady;
    endsequence

    sequence strobeHeldS;
        q.phase == ST_STROBE && !(q.pinOut[IDX_RD] && q.pinOut[IDX_WR]);
    endsequence

    property stretchP;
        stretchS |=> strobeHeldS;
    endproperty

    // straps are visible only after the edge that leaves init; the reset value is not judged
    sequence leftInitS;
        $past(q.phase == ST_INIT) && q.phase != ST_INIT;
    endsequence

    pins_float_init_a: assert property (q.phase == ST_INIT |-> q.pinOe == '0)
        else $error("strap pins driven before release");
    cycle_min_time_a: assert property (q.rspValid |->
        sinceStart >= 8'(cyclesFor(strap.mode)))
        else $error("drive cycle shorter than strapped time");
    ready_stretch_a: assert property (stretchP)
        else $error("strobe ended while channel not ready");
    read_strobe_a: assert property (q.phase == ST_STROBE && !q.cur.write |->
        !driveReadStrobeN && driveWriteStrobeN)
        else $error("read strobe not low in read");
    addr_pins_a: assert property (inCycle |->
        q.pinOut[IDX_ADDR_HI:IDX_ADDR_LO] == q.cur.addr && driveAddrMsbOe)
        else $error("drive address pins wrong");
    select_lines_a: assert property (q.phase == ST_STROBE |->
        primaryCommandSelectNOut == q.cur.ctrlBlock
        && primaryControlSelectNOut == !q.cur.ctrlBlock)
        else $error("chip select decode wrong");
    narrow_data_a: assert property (q.rspValid && !q.rdWide |->
        q.rdData[15:8] == 8'h00)
        else $error("upper byte kept on narrow read");
    prefetch_strap_a: assert property (leftInitS |->
        q.prefetch == $past(driveAddrMsbIn))
        else $error("prefetch strap not copied");
    speed_strap_a: assert property (leftInitS |->
        busSpeed25 == $past(primaryCommandSelectNIn)
        && floppyPortIgnore == $past(primaryControlSelectNIn))
        else $error("select straps not latched");
    test_entry_a: assert property (q.phase == ST_IDLE && q.reqReady
        && !strap.testModeN |=> q.phase == ST_TEST)
        else $error("test strap ignored");
    test_float_a: assert property (q.phase == ST_TEST && strap.mode == TEST_TRISTATE
        |=> q.pinOe == '0)
        else $error("pins driven in float test");
    test_nand_a: assert property (q.phase == ST_TEST && strap.mode == TEST_NAND
        |=> nandChainOe && diskDataBusOe == 16'h0000 && !driveAddrMsbOe)
        else $error("nand test pin states wrong");
    test_even_a: assert property (q.phase == ST_TEST && strap.mode == TEST_EVEN_HIGH
        |=> q.pinOe == '1 && q.pinOut[IDX_ADDR_LO] && !q.pinOut[IDX_ADDR_HI])
        else $error("even high pattern wrong");
    test_odd_a: assert property (q.phase == ST_TEST && strap.mode == TEST_ODD_HIGH
        |=> q.pinOe == '1 && !q.pinOut[IDX_ADDR_LO] && q.pinOut[IDX_ADDR_HI])
        else $error("odd high pattern wrong");

endmodule

// ---- rtl/ide_strap_pkg.sv ----
package ide_strap_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int CYCLE_MODE0_NS = 600;
    localparam int CYCLE_MODE1_NS = 383;
    localparam int CYCLE_MODE2_NS = 240;
    localparam int CYCLE_MODE3_NS = 180;
    // least times round up to whole clocks
    localparam int CYCLE_MODE0_CLKS = (CYCLE_MODE0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYCLE_MODE1_CLKS = (CYCLE_MODE1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYCLE_MODE2_CLKS = (CYCLE_MODE2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYCLE_MODE3_CLKS = (CYCLE_MODE3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int PIN_COUNT = 24;
    localparam int CHAIN_WIDTH = 24;
    localparam int IDX_ADDR_LO = 0;
    localparam int IDX_ADDR_HI = 2;
    localparam int IDX_CS_CMD = 3;
    localparam int IDX_CS_CTL = 4;
    localparam int IDX_RD = 5;
    localparam int IDX_WR = 6;
    localparam int IDX_DATA_LO = 7;
    localparam int IDX_NAND = 23;
    localparam int PIN_NUMBER [PIN_COUNT] = '{52, 53, 51, 49, 48, 57, 59,
        60, 61, 62, 63, 64, 65, 67, 68, 69, 70, 71, 72, 73, 74, 75, 76, 42};
    localparam logic [PIN_COUNT-1:0] PIN_OUT_RESET = 24'hffffff;
    localparam logic [PIN_COUNT-1:0] NORMAL_OE = 24'h00007f;
    localparam logic [PIN_COUNT-1:0] DATA_OE = 24'h7fff80;

    localparam logic [1:0] TEST_TRISTATE = 2'h0;
    localparam logic [1:0] TEST_NAND = 2'h1;
    localparam logic [1:0] TEST_EVEN_HIGH = 2'h2;
    localparam logic [1:0] TEST_ODD_HIGH = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [3:0] REG_STRAP = 4'h0;
    localparam logic [3:0] REG_MISC = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam int STRAP_SPEED_BIT = 0;
    localparam int STRAP_MODE_LSB = 1;
    localparam int STRAP_TEST_BIT = 3;
    localparam int STRAP_PREF_BIT = 6;
    localparam int STRAP_FLOPPY_BIT = 7;
    localparam int MISC_PREFETCH_BIT = 6;
    localparam logic MISC_PREFETCH_RESET = 1'b0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_TEST_BIT = 1;
    localparam int STAT_WIDE_BIT = 2;

    typedef struct packed {
        logic floppyIgnore;
        logic prefetch;
        logic testModeN;
        logic [1:0] mode;
        logic speed25;
    } strap_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic ctrlBlock;
        logic [2:0] addr;
        logic [15:0] data;
    } ide_req_s;

    typedef enum logic [5:0] {
        ST_INIT = 6'h01,
        ST_IDLE = 6'h02,
        ST_SETUP = 6'h04,
        ST_STROBE = 6'h08,
        ST_RECOVER = 6'h10,
        ST_TEST = 6'h20
    } phase_e;

    function automatic logic [6:0] cyclesFor(input logic [1:0] mode);
        case (mode)
            2'h0: return 7'(CYCLE_MODE0_CLKS);
            2'h1: return 7'(CYCLE_MODE1_CLKS);
            2'h2: return 7'(CYCLE_MODE2_CLKS);
            default: return 7'(CYCLE_MODE3_CLKS);
        endcase
    endfunction

    function automatic logic pinIsOdd(input int idx);
        return (PIN_NUMBER[idx] % 2) == 1;
    endfunction

endpackage

// ---- rtl/strap_capture.sv ----
`timescale 1ns/1ps
module strap_capture (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic capture,
    input wire logic [1:0] modePins,
    input wire logic prefetchPin,
    input wire logic testPinN,
    input wire logic speedPin,
    input wire logic floppyPin,
    output ide_strap_pkg::strap_s strap
);
    import ide_strap_pkg::*;

    strap_s strap_q;
    strap_s strap_d;

    // pins are caught by the clock at release, never by the reset itself
    always_comb
    begin
        strap_d = strap_q;
        if (capture)
        begin
            strap_d.mode = modePins;
            strap_d.prefetch = prefetchPin;
            strap_d.testModeN = testPinN;
            strap_d.speed25 = speedPin;
            strap_d.floppyIgnore = floppyPin;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            strap_q <= '{floppyIgnore: 1'b0, prefetch: 1'b0, testModeN: 1'b1,
                         mode: 2'h0, speed25: 1'b0};
        else
            strap_q <= strap_d;
    end

    assign strap = strap_q;

endmodule

// ---- rtl/test_pattern.sv ----
`timescale 1ns/1ps
module test_pattern (
    input wire logic [1:0] mode,
    input wire logic [ide_strap_pkg::CHAIN_WIDTH-1:0] chainIn,
    output logic [ide_strap_pkg::PIN_COUNT-1:0] pinOut,
    output logic [ide_strap_pkg::PIN_COUNT-1:0] pinOe
);
    import ide_strap_pkg::*;

    logic chain;

    always_comb
    begin
        chain = 1'b1;
        for (int i = 0; i < CHAIN_WIDTH; i++)
            chain = ~(chain & chainIn[i]);
        pinOut = PIN_OUT_RESET;
        pinOe = '0;
        case (mode)
            TEST_TRISTATE:
                pinOe = '0;
            TEST_NAND:
            begin
                // strobes are pure outputs, so they stay driven and idle
                pinOut[IDX_NAND] = chain;
                pinOe[IDX_NAND] = 1'b1;
                pinOe[IDX_RD] = 1'b1;
                pinOe[IDX_WR] = 1'b1;
            end
            TEST_EVEN_HIGH:
            begin
                for (int i = 0; i < PIN_COUNT; i++)
                    pinOut[i] = ~pinIsOdd(i);
                pinOe = '1;
            end
            default:
            begin
                for (int i = 0; i < PIN_COUNT; i++)
                    pinOut[i] = pinIsOdd(i);
                pinOe = '1;
            end
        endcase
    end

endmodule
